//--- logic/cfg_regs_defines.svh
// register offsets, reset values and field positions of the configuration slice
`ifndef CFG_REGS_DEFINES_SVH
`define CFG_REGS_DEFINES_SVH
`define IDX_SERIAL_SETUP   8'h02
`define IDX_FLOPPY_OPTION  8'h03
`define IDX_EXT_SETUP      8'h04
`define RST_SERIAL_SETUP   8'hDC
`define RST_FLOPPY_OPTION  8'h78
`define RST_EXT_SETUP      8'h00
`define RST_THIRD_FOURTH   2'h0
`define FLOPPY_WR_MASK     8'hFE
`define ADDR_1ST           10'h3F8
`define ADDR_2ND           10'h2F8
`define ADDR_3RD_0         10'h338
`define ADDR_3RD_1         10'h3E8
`define ADDR_3RD_2         10'h2E8
`define ADDR_3RD_3         10'h220
`define ADDR_4TH_0         10'h238
`define ADDR_4TH_1         10'h2E8
`define ADDR_4TH_2         10'h2E0
`define ADDR_4TH_3         10'h228
`define RST_INDEX          8'h00
`define RD_IDLE            8'h00
`define SER_STRIDE         4
`define SER_EN_OFS         2
`define SER_PWR_OFS        3
`define FO_ENH_BIT         1
`define FO_OPT0_BIT        3
`define FO_OPT1_BIT        4
`define FO_ENC_BIT         5
`define FO_IDENT_BIT       6
`endif

//--- logic/cfg_regs_pkg.sv
// types shared by the configuration register slice
package cfg_regs_pkg;
  typedef struct packed {
    logic       enable;
    logic       power_ok;
    logic [9:0] base;
  } serial_cfg_t;

  typedef enum logic [1:0] {
    MODE_AT,
    MODE_RESERVED,
    MODE_ALT_A,
    MODE_ALT_B
  } floppy_if_mode_t;
endpackage

//--- logic/serial_floppy_config_regs.sv
// configuration register slice: serial setup, floppy option, extended setup
`timescale 1ns/1ps
`include "cfg_regs_defines.svh"
module serial_floppy_config_regs import cfg_regs_pkg::*; (
  input  wire logic            mclk,
  input  wire logic            sys_rst,
  input  wire logic            power_on_rst,
  input  wire logic            config_mode,
  input  wire logic            index_wr,
  input  wire logic            data_wr,
  input  wire logic            data_rd,
  input  wire logic [7:0]      wr_data,
  input  wire logic [1:0]      third_fourth_sel,
  input  wire logic [1:0]      rate_select_bits,
  output logic [7:0]           rd_data,
  output serial_cfg_t          serial_primary,
  output serial_cfg_t          serial_secondary,
  output logic                 enhanced_floppy_second,
  output floppy_if_mode_t      floppy_mode,
  output logic [7:0]           parallel_serial_extended_setup,
  output logic                 rate_pin_high,
  output logic                 rate_pin_low
);

  // ------------------------------------------------------------
  // register state
  // ------------------------------------------------------------
  logic [7:0]      config_index_register_q, config_index_register_d;
  logic [7:0]      serial_port_setup_q, serial_port_setup_d;
  logic [7:0]      floppy_option_setup_q, floppy_option_setup_d;
  logic [7:0]      ext_setup_q, ext_setup_d;
  logic [7:0]      rd_data_d;
  logic            enh_d;
  floppy_if_mode_t mode_d;
  logic [1:0]      rate_d;
  logic            index_hit;
  logic            data_wr_hit;
  logic            data_rd_hit;
  wire serial_cfg_t ser_d [2];

  // ------------------------------------------------------------
  // base address decode
  // ------------------------------------------------------------
  // selects 10 and 11 reach the third and fourth addresses, whose
  // choice lives in a field outside this slice
  function automatic logic [9:0] base_of(input logic [1:0] sel, input logic [1:0] tf);
    logic [9:0] b;
    b = `ADDR_1ST;
    case (sel)
      2'h0: b = `ADDR_1ST;
      2'h1: b = `ADDR_2ND;
      2'h2: begin
        case (tf)
          2'h0:    b = `ADDR_3RD_0;
          2'h1:    b = `ADDR_3RD_1;
          2'h2:    b = `ADDR_3RD_2;
          default: b = `ADDR_3RD_3;
        endcase
      end
      default: begin
        case (tf)
          2'h0:    b = `ADDR_4TH_0;
          2'h1:    b = `ADDR_4TH_1;
          2'h2:    b = `ADDR_4TH_2;
          default: b = `ADDR_4TH_3;
        endcase
      end
    endcase
    return b;
  endfunction

  // ------------------------------------------------------------
  // access qualifiers
  // ------------------------------------------------------------
  // every strobe is ignored outside configuration mode
  always_comb begin
    index_hit   = config_mode && index_wr;
    data_wr_hit = config_mode && data_wr;
    data_rd_hit = config_mode && data_rd;
  end

  // ------------------------------------------------------------
  // index register
  // ------------------------------------------------------------
  always_comb begin
    config_index_register_d = config_index_register_q;
    if (index_hit) begin
      config_index_register_d = wr_data;
    end
  end

  // host state: the ordinary reset clears it, so software reloads it
  always_ff @(posedge mclk) begin
    if (sys_rst || power_on_rst) begin
      config_index_register_q <= `RST_INDEX;
    end else begin
      config_index_register_q <= config_index_register_d;
    end
  end

  // ------------------------------------------------------------
  // configuration registers
  // ------------------------------------------------------------
  // a data access in the cycle of an index write uses the old index
  always_comb begin
    serial_port_setup_d   = serial_port_setup_q;
    floppy_option_setup_d = floppy_option_setup_q;
    ext_setup_d           = ext_setup_q;
    if (data_wr_hit) begin
      // bit 0 of the floppy option is dropped so it always reads zero
      case (config_index_register_q)
        `IDX_SERIAL_SETUP:  serial_port_setup_d = wr_data;
        `IDX_FLOPPY_OPTION: floppy_option_setup_d = wr_data & `FLOPPY_WR_MASK;
        `IDX_EXT_SETUP:     ext_setup_d = wr_data;
        default:            ;
      endcase
    end
  end

  // power-up alone loads defaults; the ordinary reset keeps settings
  always_ff @(posedge mclk) begin
    if (power_on_rst) begin
      serial_port_setup_q   <= `RST_SERIAL_SETUP;
      floppy_option_setup_q <= `RST_FLOPPY_OPTION;
      ext_setup_q           <= `RST_EXT_SETUP;
    end else begin
      serial_port_setup_q   <= serial_port_setup_d;
      floppy_option_setup_q <= floppy_option_setup_d;
      ext_setup_q           <= ext_setup_d;
    end
  end

  // ------------------------------------------------------------
  // read path
  // ------------------------------------------------------------
  // read data idles at zero so a stray sample never shows contents;
  // unmapped indexes read as zero as well
  always_comb begin
    rd_data_d = `RD_IDLE;
    if (data_rd_hit) begin
      case (config_index_register_q)
        `IDX_SERIAL_SETUP:  rd_data_d = serial_port_setup_q;
        `IDX_FLOPPY_OPTION: rd_data_d = floppy_option_setup_q;
        `IDX_EXT_SETUP:     rd_data_d = ext_setup_q;
        default:            rd_data_d = `RD_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst || power_on_rst) begin
      rd_data <= `RD_IDLE;
    end else begin
      rd_data <= rd_data_d;
    end
  end

  // ------------------------------------------------------------
  // serial port decode
  // ------------------------------------------------------------
  // both ports share one field layout, one nibble apart
  generate
    for (genvar ch = 0; ch < 2; ch++) begin : g_serial
      localparam int SEL_LSB = `SER_STRIDE * ch;
      assign ser_d[ch] = {serial_port_setup_q[SEL_LSB + `SER_EN_OFS],
                          serial_port_setup_q[SEL_LSB + `SER_PWR_OFS],
                          base_of(serial_port_setup_q[SEL_LSB + 1:SEL_LSB], third_fourth_sel)};
    end
  endgenerate

  // ------------------------------------------------------------
  // floppy decode
  // ------------------------------------------------------------
  always_comb begin
    enh_d = floppy_option_setup_q[`FO_ENH_BIT];
    // the reserved combination is decoded so software can see it
    case ({floppy_option_setup_q[`FO_IDENT_BIT], floppy_option_setup_q[`FO_ENC_BIT]})
      2'b11:   mode_d = MODE_AT;
      2'b10:   mode_d = MODE_RESERVED;
      2'b00:   mode_d = MODE_ALT_A;
      default: mode_d = MODE_ALT_B;
    endcase
    // option bits other than 00 have no fixed mapping here, so the
    // pins follow the raw select code
    rate_d = rate_select_bits;
    if (!floppy_option_setup_q[`FO_OPT0_BIT] && !floppy_option_setup_q[`FO_OPT1_BIT]) begin
      case (rate_select_bits)
        2'h3:    rate_d = 2'b11;
        2'h0:    rate_d = 2'b00;
        2'h1:    rate_d = 2'b01;
        default: rate_d = 2'b10;
      endcase
    end
  end

  // ------------------------------------------------------------
  // output registers
  // ------------------------------------------------------------
  // outputs read as zero while a reset holds, then refill from the registers
  always_ff @(posedge mclk) begin
    if (sys_rst || power_on_rst) begin
      serial_primary                 <= '0;
      serial_secondary               <= '0;
      enhanced_floppy_second         <= 1'b0;
      floppy_mode                    <= MODE_AT;
      parallel_serial_extended_setup <= 8'h00;
      rate_pin_high                  <= 1'b0;
      rate_pin_low                   <= 1'b0;
    end else begin
      serial_primary                 <= ser_d[0];
      serial_secondary               <= ser_d[1];
      enhanced_floppy_second         <= enh_d;
      floppy_mode                    <= mode_d;
      parallel_serial_extended_setup <= ext_setup_q;
      rate_pin_high                  <= rate_d[1];
      rate_pin_low                   <= rate_d[0];
    end
  end

endmodule

//--- test/cfg_regs_assertions.sv
// concurrent checks on the configuration register slice ports
`timescale 1ns/1ps
module cfg_regs_assertions import cfg_regs_pkg::*; (
  input wire logic                  mclk,
  input wire logic                  sys_rst,
  input wire logic                  power_on_rst,
  input wire logic                  config_mode,
  input wire logic                  index_wr,
  input wire logic                  data_wr,
  input wire logic                  data_rd,
  input wire logic [7:0]            wr_data,
  input wire logic [7:0]            rd_data,
  input wire serial_cfg_t           serial_primary,
  input wire serial_cfg_t           serial_secondary,
  input wire logic                  enhanced_floppy_second,
  input wire floppy_if_mode_t       floppy_mode,
  input wire logic [7:0]            parallel_serial_extended_setup
);
  logic [7:0] idx_q;
  logic [7:0] idx_d;
  always_comb idx_d = (sys_rst || power_on_rst) ? 8'h00 : (config_mode && index_wr) ? wr_data : idx_q;
  always_ff @(posedge mclk) idx_q <= idx_d;
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst || power_on_rst);
  sequence wr_at(logic [7:0] i);
    config_mode && data_wr && idx_q == i;
  endsequence
  AST_RD_IDLE: assert property (!data_rd |=> rd_data == 8'h00) else $error("rd idle");
  AST_NO_CFG: assert property (!config_mode && data_rd |=> rd_data == 8'h00) else $error("rd cfg");
  AST_EXT_WR: assert property (wr_at(8'h04) |=> ##1 parallel_serial_extended_setup == $past(wr_data, 2))
    else $error("ext");
  AST_ENH_WR: assert property (wr_at(8'h03) |=> ##1 enhanced_floppy_second == $past(wr_data[1], 2))
    else $error("enh");
  AST_MODE_WR: assert property (wr_at(8'h03) |=> ##1 floppy_mode == {~$past(wr_data[6], 2),
    $past(wr_data[6], 2) ^ $past(wr_data[5], 2)}) else $error("mode");
  AST_PRI_WR: assert property (wr_at(8'h02) |=> ##1 serial_primary.enable == $past(wr_data[2], 2)
    && serial_primary.power_ok == $past(wr_data[3], 2)) else $error("pri");
  AST_SEC_WR: assert property (wr_at(8'h02) |=> ##1 serial_secondary.enable == $past(wr_data[6], 2)
    && serial_secondary.power_ok == $past(wr_data[7], 2)) else $error("sec");
  AST_PRI_BASE: assert property (wr_at(8'h02) ##0 wr_data[1:0] == 2'h0 |=> ##1
    serial_primary.base == 10'h3F8) else $error("base");
  AST_FLOPPY_RSVD: assert property (config_mode && data_rd && idx_q == 8'h03 |=> rd_data[0] == 1'b0)
    else $error("floppy bit 0");
endmodule
bind serial_floppy_config_regs cfg_regs_assertions u_chk (.mclk, .sys_rst, .power_on_rst, .config_mode,
  .index_wr, .data_wr, .data_rd, .wr_data, .rd_data, .serial_primary, .serial_secondary,
  .enhanced_floppy_second, .floppy_mode, .parallel_serial_extended_setup);

//--- test/tb_top.sv
// self-checking bench for the configuration register slice
`timescale 1ns/1ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin errors++; \
  $display("BAD t=%0t got=%0h exp=%0h", $time, a, e); end end
module tb_top import cfg_regs_pkg::*;;
  logic mclk = 0, sys_rst = 1, power_on_rst = 1, config_mode = 0, index_wr = 0, data_wr = 0, data_rd = 0, rd_q = 0;
  logic [7:0] wr_data = 8'h00, rd_data, parallel_serial_extended_setup, v, exp_rd;
  logic [1:0] third_fourth_sel = 2'h0, rate_select_bits = 2'h0;
  logic enhanced_floppy_second, rate_pin_high, rate_pin_low;
  serial_cfg_t serial_primary, serial_secondary;
  floppy_if_mode_t floppy_mode;
  logic [7:0] exp_q[$];
  int errors = 0, compares = 0, k, r;
  localparam logic [9:0] T3 [4] = '{10'h338, 10'h3E8, 10'h2E8, 10'h220};
  localparam logic [9:0] T4 [4] = '{10'h238, 10'h2E8, 10'h2E0, 10'h228};
  serial_floppy_config_regs DUT (.mclk, .sys_rst, .power_on_rst, .config_mode, .index_wr, .data_wr, .data_rd,
    .wr_data, .third_fourth_sel, .rate_select_bits, .rd_data, .serial_primary, .serial_secondary,
    .enhanced_floppy_second, .floppy_mode, .parallel_serial_extended_setup, .rate_pin_high, .rate_pin_low);
  initial forever #2 mclk = ~mclk;
  function automatic logic [9:0] bf(input logic [1:0] s);
    return s == 2'h0 ? 10'h3F8 : s == 2'h1 ? 10'h2F8 : s == 2'h2 ? T3[third_fourth_sel] : T4[third_fourth_sel];
  endfunction
  task conclude;
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task wr(input logic [7:0] i, input logic [7:0] d);
    @(posedge mclk); index_wr <= 1; wr_data <= i;
    @(posedge mclk); index_wr <= 0; data_wr <= 1; wr_data <= d;
    @(posedge mclk); data_wr <= 0;
    repeat (2) @(posedge mclk);
    #1;
  endtask
  task rd(input logic [7:0] i, input logic [7:0] e);
    @(posedge mclk); index_wr <= 1; wr_data <= i;
    @(posedge mclk); index_wr <= 0; data_rd <= 1; exp_q.push_back(e);
    @(posedge mclk); data_rd <= 0;
    @(posedge mclk);
  endtask
  // --------------------------------------------------------------
  // read monitor
  // --------------------------------------------------------------
  always @(posedge mclk) rd_q <= data_rd;
  always @(negedge mclk) if (rd_q) begin
    if (exp_q.size() == 0) begin
      errors++;
      $display("BAD t=%0t got=%0h exp=%0h", $time, rd_data, 8'h00);
    end else begin
      exp_rd = exp_q.pop_front();
      `CHK(rd_data, exp_rd)
    end
  end
  initial begin
    #100000;
    errors++;
    conclude;
  end
  // --------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------
  initial begin
    void'($urandom(64417));
    repeat (6) @(posedge mclk);
    sys_rst <= 0; power_on_rst <= 0; config_mode <= 1;
    rd(8'h02, 8'hDC);
    rd(8'h03, 8'h78);
    rd(8'h04, 8'h00);
    rd(8'h05, 8'h00);
    for (k = 0; k < 8; k++) begin
      v = 8'($urandom); v[1:0] = k[1:0]; v[5:4] = ~k[1:0];
      third_fourth_sel <= 2'($urandom);
      wr(8'h02, v);
      `CHK(serial_primary, {v[2], v[3], bf(v[1:0])})
      `CHK(serial_secondary, {v[6], v[7], bf(v[5:4])})
      rd(8'h02, v);
    end
    for (k = 0; k < 4; k++) begin
      v = 8'($urandom); v[6:5] = k[1:0]; v[4:3] = k[1:0];
      wr(8'h03, v);
      `CHK(floppy_mode, {~v[6], v[6] ^ v[5]})
      `CHK(enhanced_floppy_second, v[1])
      rd(8'h03, v & 8'hFE);
      for (r = 0; r < 4; r++) begin
        @(posedge mclk);
        rate_select_bits <= r[1:0];
        repeat (2) @(posedge mclk);
        #1;
        `CHK({rate_pin_high, rate_pin_low}, r[1:0])
      end
    end
    v = 8'($urandom);
    wr(8'h04, v);
    `CHK(parallel_serial_extended_setup, v)
    @(posedge mclk);
    config_mode <= 0;
    wr(8'h04, ~v);
    rd(8'h04, 8'h00);
    config_mode <= 1;
    sys_rst <= 1;
    repeat (2) @(posedge mclk);
    sys_rst <= 0;
    rd(8'h04, v);
    conclude;
  end
endmodule
